// ---- rtl/ctsync_consts.svh ----
// Summary of operation
// - the slow sample oscillator has a six-bit trim field resetting to 0x12, each step about 0.6 kHz.
// - a larger slow trim code makes the slow oscillator run slower.
// - slow trim code 00 0000 is fastest, 10 0010 is centre and 11 1111 is slowest.
// - the fast timing oscillator has an eight-bit trim field resetting to 0x98, each step about 109 kHz.
// - fast trim frequency rises with the code, from 0000 0000 lowest through 1001 1000 default to all ones highest.
// - the pin b output driver is enabled only while config bit 6 is set, reset 0.
// - the pin b input buffer is enabled only while config bit 5 is set, reset 0.
// - trigger select 00 in bits 3:2 times sample cycles from the slow oscillator at the programmed sample rate.
// - trigger select 01 starts each sample cycle on a trigger from pin a.
// - trigger select 10 starts each sample cycle on a trigger from pin b; code 11 is reserved.
`ifndef CTSYNC_CONSTS_SVH
`define CTSYNC_CONSTS_SVH
`define CTS_ADDR_SLOW 8'h4b
`define CTS_ADDR_FAST 8'h4d
`define CTS_ADDR_CFG 8'h4f
`define CTS_SLOW_RST 6'h12
`define CTS_SLOW_CENTRE 6'h22
`define CTS_SLOW_RSVD 16'h2600
`define CTS_FAST_RST 8'h98
`define CTS_FAST_RSVD 16'h0000
`define CTS_CFG_RSVD 16'h2090
`define CTS_CFG_RSVD_MASK 16'hff90
`define CTS_SLOW_RSVD_MASK 16'hfe40
`define CTS_FAST_RSVD_MASK 16'hff00
`define CTS_ADDR_STARTUP 8'h38
`define CTS_STARTUP_WORD 16'h4000
`define CTS_BIT_OE 6
`define CTS_BIT_IE 5
`define CTS_BIT_BYP 8
`define CTS_BIT_CKEN 7
`define CTS_SEL_HI 3
`define CTS_SEL_LO 2
`define CTS_SLOW_HI 5
`define CTS_FAST_HI 7
`define CTS_RATE_RST 16'h0140
`endif

// ---- rtl/ctsync_pkg.sv ----
package ctsync_pkg;
  typedef enum logic [1:0] {
    CTS_SEL_INTERNAL = 2'b00,
    CTS_SEL_PIN_A = 2'b01,
    CTS_SEL_PIN_B = 2'b10,
    CTS_SEL_RSVD = 2'b11
  } ctsync_sel_t;
endpackage : ctsync_pkg

// ---- rtl/ctsync_top.sv ----
`timescale 1ns/1ps
`include "ctsync_consts.svh"
module ctsync_top #(
  parameter int RATE_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  // oscillator trims and controls
  output logic [5:0] slow_osc_trim,
  output logic [5:0] slow_osc_speed,
  output logic [7:0] fast_osc_trim,
  output logic slow_osc_bypass,
  output logic slow_osc_enable,
  // sample timing
  input wire logic slow_tick,
  input wire logic [RATE_W-1:0] programmed_sample_rate,
  // general pins
  input wire logic general_pin_a_in,
  input wire logic general_pin_b_in,
  output logic pin_b_output_enable,
  output logic pin_b_input_enable,
  output logic general_pin_b_oe_n,
  // sequencer start
  output ctsync_pkg::ctsync_sel_t sample_trigger_select,
  output logic sample_start
);

  logic [15:0] slow_q, slow_d, fast_q, fast_d, cfg_q, cfg_d;
  logic [RATE_W-1:0] cnt_q, cnt_d;
  logic [1:0] a_sync_q, a_sync_d, b_sync_q, b_sync_d;
  logic a_prev_q, a_prev_d, b_prev_q, b_prev_d;
  logic start_q, start_d;
  logic [15:0] rdata_q, rdata_d;
  logic hit_q, hit_d;
  logic pin_b_gated;

  function automatic logic [15:0] merge_rsvd(input logic [15:0] w,
      input logic [15:0] rsvd, input logic [15:0] mask);
    merge_rsvd = (w & ~mask) | (rsvd & mask);
  endfunction : merge_rsvd

  function automatic logic rise(input logic now_v, input logic was_v);
    rise = now_v & ~was_v;
  endfunction : rise

  // register writes, reserved bits held
  always_comb begin
    slow_d = slow_q;
    fast_d = fast_q;
    cfg_d = cfg_q;
    if (reg_wr) begin
      case (reg_addr)
        `CTS_ADDR_SLOW: begin
          slow_d = merge_rsvd(reg_wdata, `CTS_SLOW_RSVD,
                              `CTS_SLOW_RSVD_MASK);
        end
        `CTS_ADDR_FAST: begin
          fast_d = merge_rsvd(reg_wdata, `CTS_FAST_RSVD,
                              `CTS_FAST_RSVD_MASK);
        end
        `CTS_ADDR_CFG: begin
          cfg_d = merge_rsvd(reg_wdata, `CTS_CFG_RSVD,
                             `CTS_CFG_RSVD_MASK);
        end
        default: begin
        end
      endcase
    end
  end

  // register readback
  always_comb begin
    hit_d = 1'b0;
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `CTS_ADDR_SLOW: begin
          hit_d = 1'b1;
          rdata_d = slow_q;
        end
        `CTS_ADDR_FAST: begin
          hit_d = 1'b1;
          rdata_d = fast_q;
        end
        `CTS_ADDR_CFG: begin
          hit_d = 1'b1;
          rdata_d = cfg_q;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slow_q <= `CTS_SLOW_RSVD | {10'h000, `CTS_SLOW_RST};
      fast_q <= `CTS_FAST_RSVD | {8'h00, `CTS_FAST_RST};
      cfg_q <= `CTS_CFG_RSVD;
      rdata_q <= 16'h0000;
      hit_q <= 1'b0;
    end else begin
      slow_q <= slow_d;
      fast_q <= fast_d;
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_hit = hit_q;
  assign slow_osc_trim = slow_q[`CTS_SLOW_HI:0];
  // speed code falls as trim rises: trim 00 (speed 3f) fastest, trim 3f (speed 00) slowest
  assign slow_osc_speed = ~slow_q[`CTS_SLOW_HI:0];
  assign fast_osc_trim = fast_q[`CTS_FAST_HI:0];
  assign slow_osc_bypass = slow_q[`CTS_BIT_BYP];
  assign slow_osc_enable = slow_q[`CTS_BIT_CKEN];
  assign pin_b_output_enable = cfg_q[`CTS_BIT_OE];
  assign general_pin_b_oe_n = ~cfg_q[`CTS_BIT_OE];
  assign pin_b_input_enable = cfg_q[`CTS_BIT_IE];
  assign sample_trigger_select =
    ctsync_pkg::ctsync_sel_t'(cfg_q[`CTS_SEL_HI:`CTS_SEL_LO]);
  assign pin_b_gated = general_pin_b_in & cfg_q[`CTS_BIT_IE];

  // pin trigger synchronisers and edge detect
  always_comb begin
    a_sync_d = {a_sync_q[0], general_pin_a_in};
    b_sync_d = {b_sync_q[0], pin_b_gated};
    a_prev_d = a_sync_q[1];
    b_prev_d = b_sync_q[1];
  end

  // sample start selection
  always_comb begin
    cnt_d = cnt_q;
    start_d = 1'b0;
    case (sample_trigger_select)
      ctsync_pkg::CTS_SEL_INTERNAL: begin
        if (slow_tick && slow_osc_enable) begin
          if (cnt_q >= programmed_sample_rate - RATE_W'(1) ||
              programmed_sample_rate == '0) begin
            cnt_d = '0;
            start_d = 1'b1;
          end else begin
            cnt_d = cnt_q + RATE_W'(1);
          end
        end
      end
      ctsync_pkg::CTS_SEL_PIN_A: begin
        cnt_d = '0;
        start_d = rise(a_sync_q[1], a_prev_q);
      end
      ctsync_pkg::CTS_SEL_PIN_B: begin
        cnt_d = '0;
        start_d = rise(b_sync_q[1], b_prev_q);
      end
      default: begin
        cnt_d = '0;
        start_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      a_sync_q <= 2'h0;
      b_sync_q <= 2'h0;
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
      cnt_q <= '0;
      start_q <= 1'b0;
    end else begin
      a_sync_q <= a_sync_d;
      b_sync_q <= b_sync_d;
      a_prev_q <= a_prev_d;
      b_prev_q <= b_prev_d;
      cnt_q <= cnt_d;
      start_q <= start_d;
    end
  end

  assign sample_start = start_q;

  // register file checks
  a_slow_reset: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> slow_osc_trim == `CTS_SLOW_RST)
    else $error("slow trim not at reset value");
  a_slow_invert: assert property (@(posedge clk_sys)
    disable iff (!rst_n) slow_osc_speed == 6'h3f - slow_osc_trim)
    else $error("slow speed not inverse of trim");
  a_slow_centre: assert property (@(posedge clk_sys)
    disable iff (!rst_n) slow_osc_trim == `CTS_SLOW_CENTRE
    |-> slow_osc_speed == 6'h1d)
    else $error("slow centre code mapped wrong");
  a_fast_write: assert property (@(posedge clk_sys)
    disable iff (!rst_n) reg_wr && reg_addr == `CTS_ADDR_FAST
    |=> fast_osc_trim == $past(reg_wdata[7:0]))
    else $error("fast trim write lost");
  a_fast_reset: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> fast_osc_trim == `CTS_FAST_RST)
    else $error("fast trim not at reset value");
  a_pin_oe: assert property (@(posedge clk_sys)
    disable iff (!rst_n) reg_wr && reg_addr == `CTS_ADDR_CFG
    |=> general_pin_b_oe_n == !$past(reg_wdata[`CTS_BIT_OE]))
    else $error("pin b driver not following config");
  a_pin_ie: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !pin_b_input_enable
    && sample_trigger_select == ctsync_pkg::CTS_SEL_PIN_B
    ##2 sample_trigger_select == ctsync_pkg::CTS_SEL_PIN_B |=> !sample_start)
    else $error("pin b trigger passed with input off");
  a_pin_a_start: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    sample_trigger_select == ctsync_pkg::CTS_SEL_PIN_A [*4]
    ##0 $rose(a_prev_q) |-> sample_start)
    else $error("pin a edge did not start a cycle");
  a_rsvd_quiet: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    sample_trigger_select == ctsync_pkg::CTS_SEL_RSVD |=> !sample_start)
    else $error("reserved select started a cycle");
  a_cfg_rsvd: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (cfg_q & `CTS_CFG_RSVD_MASK) == `CTS_CFG_RSVD)
    else $error("config reserved bits changed");
  a_internal_gap: assert property (@(posedge clk_sys)
    disable iff (!rst_n) sample_start
    && sample_trigger_select == ctsync_pkg::CTS_SEL_INTERNAL
    && programmed_sample_rate > RATE_W'(1) |=> !sample_start)
    else $error("internal starts too close");
  a_slow_write: assert property (@(posedge clk_sys)
    disable iff (!rst_n) reg_wr && reg_addr == `CTS_ADDR_SLOW
    |=> slow_osc_trim == $past(reg_wdata[`CTS_SLOW_HI:0]))
    else $error("slow trim write lost");
  a_sel_write: assert property (@(posedge clk_sys)
    disable iff (!rst_n) reg_wr && reg_addr == `CTS_ADDR_CFG
    |=> sample_trigger_select == $past(reg_wdata[`CTS_SEL_HI:`CTS_SEL_LO]))
    else $error("trigger select write lost");
  a_slow_rsvd: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (slow_q & `CTS_SLOW_RSVD_MASK) == `CTS_SLOW_RSVD)
    else $error("slow trim reserved bits changed");
  a_fast_rsvd: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (fast_q & `CTS_FAST_RSVD_MASK) == `CTS_FAST_RSVD)
    else $error("fast trim reserved bits changed");
  a_read_fast: assert property (@(posedge clk_sys)
    disable iff (!rst_n) reg_rd && reg_addr == `CTS_ADDR_FAST
    |=> reg_hit && reg_rdata == $past(fast_q))
    else $error("fast trim readback wrong");
  a_unmapped_rd: assert property (@(posedge clk_sys)
    disable iff (!rst_n) reg_rd && reg_addr != `CTS_ADDR_SLOW
    && reg_addr != `CTS_ADDR_FAST && reg_addr != `CTS_ADDR_CFG
    |=> !reg_hit && reg_rdata == 16'h0000)
    else $error("unmapped read answered");
  a_unmapped_wr: assert property (@(posedge clk_sys)
    disable iff (!rst_n) reg_wr && reg_addr != `CTS_ADDR_SLOW
    && reg_addr != `CTS_ADDR_FAST && reg_addr != `CTS_ADDR_CFG
    |=> $stable(slow_q) && $stable(fast_q) && $stable(cfg_q))
    else $error("unmapped write changed a register");

  // pin and start checks
  a_oe_pair: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    general_pin_b_oe_n == !pin_b_output_enable)
    else $error("pin b enable pair disagrees");
  a_pin_b_start: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    sample_trigger_select == ctsync_pkg::CTS_SEL_PIN_B [*4]
    ##0 $rose(b_prev_q) |-> sample_start)
    else $error("pin b edge did not start a cycle");
  a_rate_zero: assert property (@(posedge clk_sys)
    disable iff (!rst_n) slow_tick && slow_osc_enable
    && sample_trigger_select == ctsync_pkg::CTS_SEL_INTERNAL
    && programmed_sample_rate == '0 |=> sample_start)
    else $error("rate zero tick did not start");
  a_enable_gate: assert property (@(posedge clk_sys)
    disable iff (!rst_n) !slow_osc_enable
    && sample_trigger_select == ctsync_pkg::CTS_SEL_INTERNAL
    |=> !sample_start)
    else $error("start with slow clock disabled");
  a_start_single: assert property (@(posedge clk_sys)
    disable iff (!rst_n) sample_start
    && sample_trigger_select != ctsync_pkg::CTS_SEL_INTERNAL
    |=> !sample_start)
    else $error("pin start lasted two cycles");

  c_internal: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sample_start && sample_trigger_select == ctsync_pkg::CTS_SEL_INTERNAL);
  c_pin_a: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sample_start && sample_trigger_select == ctsync_pkg::CTS_SEL_PIN_A);
  c_pin_b: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sample_start && sample_trigger_select == ctsync_pkg::CTS_SEL_PIN_B);
  c_rate_zero: cover property (@(posedge clk_sys) disable iff (!rst_n)
    slow_tick && programmed_sample_rate == '0 ##1 sample_start);
  c_reserved: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sample_trigger_select == ctsync_pkg::CTS_SEL_RSVD);

endmodule : ctsync_top

// ---- testbench/tb_ctsync_top.sv ----
`timescale 1ns/1ps
`include "ctsync_consts.svh"
module tb_ctsync_top;
  logic clk_sys, rst_n, reg_wr, reg_rd, slow_tick, pin_a, pin_b, reg_hit;
  logic [7:0] reg_addr, fast_osc_trim;
  logic [15:0] reg_wdata, reg_rdata, rate;
  logic [5:0] slow_osc_trim, slow_osc_speed;
  logic slow_osc_bypass, slow_osc_enable, oe, ie, oe_n, sample_start;
  ctsync_pkg::ctsync_sel_t sel;
  int fails, num_checks, starts, cyc;

  ctsync_top #(.RATE_W(16)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .slow_osc_trim(slow_osc_trim),
    .slow_osc_speed(slow_osc_speed), .fast_osc_trim(fast_osc_trim),
    .slow_osc_bypass(slow_osc_bypass), .slow_osc_enable(slow_osc_enable),
    .slow_tick(slow_tick), .programmed_sample_rate(rate),
    .general_pin_a_in(pin_a), .general_pin_b_in(pin_b),
    .pin_b_output_enable(oe), .pin_b_input_enable(ie),
    .general_pin_b_oe_n(oe_n), .sample_trigger_select(sel),
    .sample_start(sample_start)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // counts start pulses and cuts a hang short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (sample_start === 1'b1) starts <= starts + 1;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask : wr

  // read, then compare data and hit flag
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    logic h;
    h = (a == `CTS_ADDR_SLOW) || (a == `CTS_ADDR_FAST) || (a == `CTS_ADDR_CFG);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
    chk({15'h0000, reg_hit}, {15'h0000, h});
    @(negedge clk_sys);
  endtask : rdc

  // which: 0 pin a, 1 pin b, 2 slow tick
  task automatic pulse(input int which, input int n);
    repeat (n) begin
      if (which == 0) pin_a = 1'b1;
      else if (which == 1) pin_b = 1'b1;
      else slow_tick = 1'b1;
      repeat ((which == 2) ? 1 : 3) @(negedge clk_sys);
      pin_a = 1'b0;
      pin_b = 1'b0;
      slow_tick = 1'b0;
      repeat (6) @(negedge clk_sys);
    end
  endtask : pulse

  task automatic trig(input logic [15:0] cfg, input int which, input int n,
                      input int exp);
    int s;
    wr(`CTS_ADDR_STARTUP, (cfg[3:2] == 2'b01 || cfg[3:2] == 2'b10) ?
       `CTS_STARTUP_WORD : 16'h0000);
    wr(`CTS_ADDR_CFG, cfg);
    chk({14'h0000, sel}, {14'h0000, cfg[3:2]});
    s = starts;
    pulse(which, n);
    chk(16'(starts - s), 16'(exp));
  endtask : trig

  task automatic t_reset;
    rdc(`CTS_ADDR_SLOW, 16'h2612);
    rdc(`CTS_ADDR_FAST, 16'h0098);
    rdc(`CTS_ADDR_CFG, 16'h2090);
    rdc(8'h4c, 16'h0000);
    chk({10'h000, slow_osc_trim}, 16'h0012);
    chk({13'h0000, oe, ie, oe_n}, 16'h0001);
    chk({14'h0000, sel}, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_trim;
    wr(`CTS_ADDR_SLOW, 16'hffff);
    rdc(`CTS_ADDR_SLOW, 16'h27bf);
    chk({4'h0, slow_osc_trim, slow_osc_speed}, 16'h0fc0);
    chk({14'h0000, slow_osc_bypass, slow_osc_enable}, 16'h0003);
    wr(`CTS_ADDR_SLOW, 16'h0022);
    chk({10'h000, slow_osc_speed}, 16'h001d);
    wr(`CTS_ADDR_SLOW, 16'h0000);
    chk({10'h000, slow_osc_speed}, 16'h003f);
    wr(8'h4c, 16'hffff);
    rdc(`CTS_ADDR_SLOW, 16'h2600);
    wr(`CTS_ADDR_FAST, 16'hffff);
    rdc(`CTS_ADDR_FAST, 16'h00ff);
    wr(`CTS_ADDR_FAST, 16'h0000);
    chk({8'h00, fast_osc_trim}, 16'h0000);
    $display("test trim done");
  endtask : t_trim

  task automatic t_pins;
    wr(`CTS_ADDR_CFG, 16'h0040);
    rdc(`CTS_ADDR_CFG, 16'h20d0);
    chk({13'h0000, oe, ie, oe_n}, 16'h0004);
    wr(`CTS_ADDR_CFG, 16'h0120);
    rdc(`CTS_ADDR_CFG, 16'h20b0);
    chk({13'h0000, oe, ie, oe_n}, 16'h0003);
    $display("test pins done");
  endtask : t_pins

  task automatic t_sync;
    trig(16'h0004, 0, 2, 2);
    trig(16'h0024, 1, 1, 0);
    trig(16'h0028, 1, 2, 2);
    trig(16'h0008, 1, 1, 0);
    trig(16'h002c, 0, 1, 0);
    trig(16'h002c, 1, 1, 0);
    trig(16'h0020, 0, 1, 0);
    wr(`CTS_ADDR_SLOW, 16'h0092);
    chk({14'h0000, slow_osc_bypass, slow_osc_enable}, 16'h0001);
    trig(16'h0000, 2, 6, 2);
    rate = 16'h0000;
    trig(16'h0000, 2, 3, 3);
    wr(`CTS_ADDR_SLOW, 16'h0012);
    trig(16'h0000, 2, 3, 0);
    $display("test sync done");
  endtask : t_sync

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  initial begin
    {rst_n, reg_wr, reg_rd, slow_tick, pin_a, pin_b} = 6'h00;
    {reg_addr, reg_wdata, rate} = {8'h00, 16'h0000, 16'h0003};
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_trim();
    t_pins();
    t_sync();
    conclude();
  end
endmodule : tb_ctsync_top
